// file: logic/sync_sram_defs.vh
// Purpose: Shared constants for the pipelined burst synchronous memory port.
// Assumes: Included by bare name from the design files.
// Notes:   Holds definitions only.
`ifndef SYNC_SRAM_DEFS_VH
`define SYNC_SRAM_DEFS_VH

// Pipeline depth between a presentation and its data cycle.
`define SRAM_DATA_LATENCY   2
// Number of beats in one burst.
`define SRAM_BURST_LEN      3'h4
// Default organisation: 512K words of 18 bits.
`define SRAM_ADDR_W         19
`define SRAM_DATA_W         18
`define SRAM_LANES          2
`define SRAM_LANE_W         9
// Burst order codes on burst_order_sel.
`define SRAM_ORDER_LINEAR   1'b0
`define SRAM_ORDER_INTERLV  1'b1
// Field positions of the packed pipeline control word.
`define SRAM_CTL_VALID      0
`define SRAM_CTL_WRITE      1
// Reset value of the control word.
`define SRAM_CTL_RESET      2'h0

`endif

// file: logic/beat_buffer.v
// Purpose: Two-entry valid/ready buffer for read beats.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Holds two words; the port ignores in_ready, so a word that arrives while both are full is lost.
`timescale 1ns/1ps
`default_nettype none

module beat_buffer #(
    parameter WIDTH = 18
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             rst_n,
    // Fill side.
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Freeze from the clock hold.
    input  wire             hold
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_ptr_q;
    reg             rd_ptr_q;
    reg [1:0]       count_q;
    wire            push;
    wire            pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid & in_ready & ~hold;
    assign pop       = out_valid & out_ready & ~hold;

    // Pointer and count update; storage holds under the freeze as well.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

    // Storage needs no reset; it is only read while valid.
    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

endmodule // beat_buffer

`default_nettype wire

// file: logic/sync_sram_port.v
// Purpose: Pipelined burst synchronous memory with zero-turnaround switching.
// Assumes: All inputs synchronous to clk except out_enable_n and rst_n; 40 MHz clock.
// Notes:   Data bus is split into in, out and output-enable (low = drive).
`timescale 1ns/1ps
`default_nettype none
`include "sync_sram_defs.vh"

// Function
// - Data cycle follows its address presentation by exactly two clocks.
// - Output enable is asynchronous and forces the data outputs off.
// - Clock hold high freezes all state except the sleeping flag, which still follows sleep_req.
// - Any inactive chip select on a load starts no new operation.
// - Transfers already in the pipeline complete despite a deselect.
// - Data bus floats two clocks after a deselect or write start.
// - Burst gives four data cycles from one external address.
// - Load low takes a new address; high advances the burst counter.
// - Address register captures only on a selected, unheld load edge.
// - A load while deselected ends any burst in progress.
// - Advance ignores the external address and uses the burst address.
// - Read/write select sampled on a load decides the operation.
// - Reads and writes follow back to back with no idle cycle.
// - Each byte lane has its own write select.
// - Array is 256K by 36 or 512K by 18, nineteen address bits.
// - Address, data and control are captured on the rising edge.
// - Output buffer enable is sequenced internally and synchronously.
// - Burst order select picks linear or interleaved sequence.
// - Sleep input puts the device into power-down.
// - Order select high is interleaved, low linear; host keeps it static.
// - Sleep gates the internal clock and keeps all stored data.
// - Two selects active low, one active high, otherwise identical.
module sync_sram_port #(
    parameter ADDR_W = `SRAM_ADDR_W,
    parameter DATA_W = `SRAM_DATA_W,
    parameter LANES  = `SRAM_LANES,
    parameter LANE_W = `SRAM_LANE_W,
    parameter DEPTH  = 16
) (
    // Clock and reset.
    input  wire              clk,
    input  wire              rst_n,
    // Address and control from the host.
    input  wire [ADDR_W-1:0] word_address,
    input  wire              advance_or_load_sel,
    input  wire              read_write_sel,
    input  wire              clock_hold_n,
    input  wire [LANES-1:0]  byte_lane_write_n,
    input  wire              chip_select_a_n,
    input  wire              chip_select_b,
    input  wire              chip_select_c_n,
    input  wire              burst_order_sel,
    input  wire              sleep_req,
    input  wire              out_enable_n,
    // Data bus, split three ways.
    input  wire [DATA_W-1:0] data_lines_in,
    output reg  [DATA_W-1:0] data_lines_out,
    output reg               data_lines_oe_n,
    // Buffered read beat stream.
    output reg               rd_beat_valid,
    input  wire              rd_beat_ready,
    output reg  [DATA_W-1:0] rd_beat_data,
    // Status.
    output reg               sleeping
);
    // Index width is the number of bits that addresses the modelled array.
    localparam IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    reg  [DATA_W-1:0] mem_q [0:DEPTH-1];
    reg  [ADDR_W-1:0] base_addr_q;
    reg  [1:0]        beat_cnt_q;
    reg               burst_act_q;
    reg               burst_wr_q;
    reg               order_q;
    // Two-stage pipeline of control and address.
    reg  [1:0]        ctl1_q;
    reg  [1:0]        ctl2_q;
    reg  [ADDR_W-1:0] addr1_q;
    reg  [ADDR_W-1:0] addr2_q;
    reg  [LANES-1:0]  lanes1_q;
    reg  [LANES-1:0]  lanes2_q;
    reg               drive_q;
    reg  [DATA_W-1:0] rd_word_q;
    reg               rd_push_q;

    wire              selected;
    wire              hold;
    wire              run;
    wire              load_op;
    wire              deselect;
    wire              advance;
    wire [ADDR_W-1:0] beat_addr;
    wire [1:0]        next_cnt;
    wire [1:0]        cur_op;
    wire [ADDR_W-1:0] cur_addr;
    wire              buf_in_ready;
    wire              buf_out_valid;
    wire [DATA_W-1:0] buf_out_data;
    wire [DATA_W-1:0] lane_mask;

    // Low two address bits of a burst beat from the base and the count.
    function [1:0] burst_low;
        input [1:0] base;
        input [1:0] cnt;
        input       order;
        begin
            if (order == `SRAM_ORDER_INTERLV) begin
                burst_low = base ^ cnt;
            end else begin
                burst_low = base + cnt;
            end
        end
    endfunction

    // Expand active-low lane selects into a bit mask.
    function [DATA_W-1:0] expand_lanes;
        input [LANES-1:0] lanes_n;
        integer i;
        begin
            expand_lanes = {DATA_W{1'b0}};
            for (i = 0; i < DATA_W; i = i + 1) begin
                expand_lanes[i] = ~lanes_n[i / LANE_W];
            end
        end
    endfunction

    assign selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
    assign hold     = clock_hold_n | sleep_req;
    assign run      = ~hold;
    assign load_op  = run & ~advance_or_load_sel & selected;
    assign deselect = run & ~advance_or_load_sel & ~selected;
    assign advance  = run & advance_or_load_sel & burst_act_q
                      & (beat_cnt_q != 2'h3);
    assign next_cnt = beat_cnt_q + 2'h1;
    assign beat_addr = {base_addr_q[ADDR_W-1:2],
                        burst_low(base_addr_q[1:0], next_cnt, order_q)};
    assign cur_addr = load_op ? word_address : beat_addr;
    assign cur_op   = load_op ? {~read_write_sel, 1'b1}
                    : (advance ? {burst_wr_q, 1'b1} : `SRAM_CTL_RESET);
    assign lane_mask = expand_lanes(lanes2_q);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_addr_q <= {ADDR_W{1'b0}};
            beat_cnt_q  <= 2'h0;
            burst_act_q <= 1'b0;
            burst_wr_q  <= 1'b0;
            order_q     <= `SRAM_ORDER_LINEAR;
        end else if (load_op) begin
            base_addr_q <= word_address;
            beat_cnt_q  <= 2'h0;
            burst_act_q <= 1'b1;
            burst_wr_q  <= ~read_write_sel;
            order_q     <= burst_order_sel;
        end else if (deselect) begin
            burst_act_q <= 1'b0;
        end else if (advance) begin
            beat_cnt_q  <= next_cnt;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl1_q   <= `SRAM_CTL_RESET;
            ctl2_q   <= `SRAM_CTL_RESET;
            addr1_q  <= {ADDR_W{1'b0}};
            addr2_q  <= {ADDR_W{1'b0}};
            lanes1_q <= {LANES{1'b1}};
            lanes2_q <= {LANES{1'b1}};
        end else if (run) begin
            ctl1_q   <= cur_op;
            ctl2_q   <= ctl1_q;
            addr1_q  <= cur_addr;
            addr2_q  <= addr1_q;
            lanes1_q <= byte_lane_write_n;
            lanes2_q <= lanes1_q;
        end
    end

    always @(posedge clk) begin
        if (run && ctl2_q[`SRAM_CTL_VALID] && ctl2_q[`SRAM_CTL_WRITE]) begin
            mem_q[addr2_q[IDX_W-1:0]] <= (mem_q[addr2_q[IDX_W-1:0]] & ~lane_mask)
                                         | (data_lines_in & lane_mask);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q   <= 1'b0;
            rd_word_q <= {DATA_W{1'b0}};
            rd_push_q <= 1'b0;
        end else if (run) begin
            drive_q   <= ctl1_q[`SRAM_CTL_VALID] & ~ctl1_q[`SRAM_CTL_WRITE];
            rd_word_q <= mem_q[addr1_q[IDX_W-1:0]];
            rd_push_q <= ctl1_q[`SRAM_CTL_VALID] & ~ctl1_q[`SRAM_CTL_WRITE];
        end
    end

    always @* begin
        data_lines_out  = rd_word_q;
        data_lines_oe_n = ~(drive_q & ~out_enable_n);
    end

    // Read beats also go to a buffer; the output stage reloads in the same
    // cycle it hands a beat over, so a ready receiver drains one per clock.
    beat_buffer #(
        .WIDTH (DATA_W)
    ) u_beat_buffer (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (rd_push_q),
        .in_ready  (buf_in_ready),
        .in_data   (rd_word_q),
        .out_valid (buf_out_valid),
        .out_ready (rd_beat_ready | ~rd_beat_valid),
        .out_data  (buf_out_data),
        .hold      (hold)
    );

    // Output stage registers the buffered beat; ready back-pressures the buffer.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_beat_valid <= 1'b0;
            rd_beat_data  <= {DATA_W{1'b0}};
        end else if (run && (!rd_beat_valid || rd_beat_ready)) begin
            // The hold freezes the handshake too, so no beat is lost under it.
            rd_beat_valid <= buf_out_valid;
            if (buf_out_valid) begin
                rd_beat_data <= buf_out_data;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= sleep_req;
        end
    end

endmodule // sync_sram_port

`default_nettype wire

// file: tb/sram_port_props.sv
// Purpose: Pin timing checks for sync_sram_port.
// Assumes: clock_hold_n high means hold.
// Notes:   Sees only the port's pins.
`timescale 1ns/1ps
`default_nettype none
module sram_port_props #(
    parameter DATA_W = 18
) (
    // Clock, reset and controls.
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              advance_or_load_sel,
    input wire logic              read_write_sel,
    input wire logic              clock_hold_n,
    input wire logic              chip_select_a_n,
    input wire logic              chip_select_b,
    input wire logic              chip_select_c_n,
    input wire logic              sleep_req,
    input wire logic              out_enable_n,
    input wire logic              rd_beat_ready,
    // Outputs.
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic              data_lines_oe_n,
    input wire logic              rd_beat_valid,
    input wire logic [DATA_W-1:0] rd_beat_data,
    input wire logic              sleeping
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Unheld edge, selection and loads; sleep counts as a hold.
    wire run = !clock_hold_n && !sleep_req;
    wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    wire ld  = run && !advance_or_load_sel;
    wire rld = ld && sel && read_write_sel;
    wire wld = ld && sel && !read_write_sel;
    rd_lat_a: assert property (rld ##1 run |=> out_enable_n || !data_lines_oe_n)
        else $error("read beat missing");
    wr_float_a: assert property (wld ##1 run |=> data_lines_oe_n)
        else $error("bus driven on write");
    desel_float_a: assert property (ld && !sel ##1 run |=> data_lines_oe_n)
        else $error("bus driven after deselect");
    oe_async_a: assert property (out_enable_n |-> data_lines_oe_n)
        else $error("bus driven while disabled");
    hold_keep_a: assert property (!run |=> $stable(data_lines_out) && $stable(rd_beat_data))
        else $error("output moved under hold");
    sleep_flag_a: assert property (sleep_req && !clock_hold_n |=> sleeping)
        else $error("sleep not shown");
    burst_four_a: assert property (rld ##1 (run && advance_or_load_sel) [*4]
        ##1 run |=> data_lines_oe_n) else $error("fifth beat driven");
    beat_stand_a: assert property (rd_beat_valid && !rd_beat_ready
        |=> rd_beat_valid && $stable(rd_beat_data)) else $error("stalled beat lost");
    // Main scenarios reached.
    cover property (rld ##1 (run && advance_or_load_sel) [*3]);
    cover property (wld ##1 clock_hold_n);
    cover property (ld && !sel);
endmodule // sram_port_props

bind sync_sram_port sram_port_props #(.DATA_W(DATA_W)) u_sram_port_props (.*);
`default_nettype wire

// file: tb/host_data_model.sv
// Purpose: Host side of the data lines and the beat receiver.
// Assumes: Write words are announced with their presentation.
// Notes:   Idle lines show the inverse of their own previous value, so they toggle each unheld edge.
`timescale 1ns/1ps
`default_nettype none
module host_data_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Presentation side.
    input  wire logic        hold,
    input  wire logic        wr_req,
    input  wire logic [17:0] wr_word,
    input  wire logic        stall,
    // Lines toward the device.
    output var  logic [17:0] data_lines_in,
    output wire logic        rd_beat_ready
);
    logic        p_vld_q;
    logic [17:0] p_word_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p_vld_q <= 1'b0;
            p_word_q <= '0;
            data_lines_in <= '0;
        end else if (!hold) begin
            p_vld_q <= wr_req;
            p_word_q <= wr_word;
            data_lines_in <= #1 p_vld_q ? p_word_q : ~data_lines_in;
        end
    end
    // Ready drops only when the bench asks for a stall.
    assign rd_beat_ready = !stall;
endmodule // host_data_model
`default_nettype wire

// file: tb/tb_sync_sram_port.sv
// Purpose: Self-checking bench for sync_sram_port.
// Assumes: 40 MHz clock, 16-word array, hold active high.
// Notes:   A bench copy of the array predicts every read.
`timescale 1ns/1ps
`default_nettype none
module tb_sync_sram_port;
    // Bench signals and expectation queues.
    logic        clk, rst_n, adv, rw, hold, csa_n, csb, csc_n, order, sleep, oe_n;
    logic        wr_req, stall, doe_n, bvalid, bready, slp, frz_q;
    logic [18:0] addr;
    logic [1:0]  ln_n;
    logic [17:0] din, dout, bdata, wword, mem [16], qb[$], qr[$];
    logic [31:0] rnd;
    int          n_fail, tests_run;

    sync_sram_port u_sync_sram_port (.clk(clk), .rst_n(rst_n), .word_address(addr),
        .advance_or_load_sel(adv), .read_write_sel(rw), .clock_hold_n(hold),
        .byte_lane_write_n(ln_n), .chip_select_a_n(csa_n), .chip_select_b(csb),
        .chip_select_c_n(csc_n), .burst_order_sel(order), .sleep_req(sleep),
        .out_enable_n(oe_n), .data_lines_in(din), .data_lines_out(dout),
        .data_lines_oe_n(doe_n), .rd_beat_valid(bvalid), .rd_beat_ready(bready),
        .rd_beat_data(bdata), .sleeping(slp));
    host_data_model u_host_data_model (.clk(clk), .rst_n(rst_n), .hold(hold | sleep),
        .wr_req(wr_req), .wr_word(wword), .stall(stall), .data_lines_in(din),
        .rd_beat_ready(bready));

    // Clock of 25 ns, and the holds seen at each edge.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) frz_q <= hold | sleep;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick();
        @(posedge clk);
        #1 rnd = lfsr(rnd);
    endtask
    task automatic cmp(input string what, input logic [17:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One load plus advances; mode 1 holds, 2 sleeps, 4 expects the outputs off and queues no bus words.
    // Addresses on advances are random on purpose, since they must be ignored.
    task automatic op(input logic r, input logic [18:0] a, input logic [1:0] l,
                      input int beats, input logic [2:0] off, input int mode);
        logic [3:0] ix;
        for (int i = 0; i < beats; i++) begin
            ix = {a[3:2], order ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
            {adv, rw, ln_n, addr} = {i != 0, r, l, i != 0 ? rnd[31:13] : a};
            {csc_n, csb, csa_n} = off ^ 3'h2;
            {wr_req, wword} = {!r && off == 3'h0, rnd[17:0]};
            if (off == 3'h0 && r) begin
                if (!mode[2]) qb.push_back(mem[ix]);
                qr.push_back(mem[ix]);
            end else if (off == 3'h0) begin
                if (!l[0]) mem[ix][8:0] = wword[8:0];
                if (!l[1]) mem[ix][17:9] = wword[17:9];
            end
            tick();
            if (i == 0 && mode[1:0] != 0) begin
                {hold, sleep, adv, rw} = {mode[0], mode[1], 1'b0, !r};
                repeat (3) tick();
                {hold, sleep} = 2'h0;
            end
        end
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            {adv, wr_req, csa_n, addr} = {2'h0, 1'b1, rnd[18:0]};
            tick();
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bus words mid-cycle once per unheld edge; beats on each handshake.
    always @(negedge clk) begin
        if (rst_n && !frz_q && doe_n === 1'b0)
            cmp("data_lines_out", qb.size() ? qb.pop_front() : 'x, dout);
    end
    always @(posedge clk) begin
        if (rst_n && bvalid === 1'b1 && bready === 1'b1 && !(hold | sleep))
            cmp("rd_beat_data", qr.size() ? qr.pop_front() : 'x, bdata);
    end

    // Reset, then the scenarios; order changes only while idle.
    initial begin
        {rst_n, adv, rw, hold, sleep, oe_n, order, stall, wr_req} = 9'h0;
        {csc_n, csb, csa_n, ln_n, addr, wword} = '0;
        {n_fail, tests_run, rnd} = {32'h0, 32'h0, 32'h1deb_2663};
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int b = 0; b < 16; b += 4) op(0, 19'(b), 2'h0, 4, 3'h0, 0);
        op(1, 19'h0_0006, 2'h0, 4, 3'h0, 0);
        idle(2);
        order = 1'b1;
        op(0, 19'h0_0009, 2'h0, 4, 3'h0, 0);
        op(1, 19'h0_0009, 2'h3, 4, 3'h0, 0);
        idle(2);
        order = 1'b0;
        for (int l = 0; l < 4; l++) begin
            op(0, 19'h0_0005, 2'(l), 1, 3'h0, 0);
            idle(2);
            op(1, 19'h0_0005, 2'h0, 1, 3'h0, 0);
        end
        for (int k = 0; k < 3; k++) begin
            op(1, 19'h0_000c, 2'h0, 1, 3'h0, 0);
            op(1, 19'h0_0002, 2'h0, 3, 3'h1 << k, 0);
        end
        op(1, 19'h0_0000, 2'h0, 4, 3'h0, 1);
        op(0, 19'h0_0004, 2'h0, 4, 3'h0, 2);
        op(1, 19'h0_0004, 2'h0, 4, 3'h0, 0);
        idle(3);
        oe_n = 1'b1;
        op(1, 19'h0_0008, 2'h0, 2, 3'h0, 4);
        idle(3);
        {oe_n, stall} = 2'h1;
        op(1, 19'h0_0001, 2'h0, 1, 3'h0, 0);
        op(1, 19'h0_000e, 2'h0, 1, 3'h0, 0);
        idle(8);
        stall = 1'b0;
        repeat (12) begin
            op(rnd[0], rnd[18:0], rnd[3:2], int'(rnd[5:4]) + 1, 3'h0, 0);
            idle(2);
        end
        for (int t = 0; t < 40 && qr.size() != 0; t++) idle(1);
        cmp("beats left", 18'h0, 18'(qr.size()));
        cmp("words left", 18'h0, 18'(qb.size()));
        end_of_test();
    end
endmodule // tb_sync_sram_port
`default_nettype wire
